// ===== core/hcr_pkg.sv
// package: hardware configuration register constants, fields and types
// Functional notes
// RQ1 - read-only ready flag at bit 27, resets low
// RQ2 - ready low after every reset source
// RQ3 - ready rising edge sets interrupt status bit
// RQ4 - host reads only four registers while not ready
// RQ5 - host expects no write effect before ready; the code still applies such writes and flags host_access_err
// RQ6 - ready mirrors power management bit zero
// RQ7 - bit 26 disables crossover on phy b
// RQ8 - bit 25 disables crossover on phy a
// RQ9 - phy special register overrides crossover setting
// RQ10 - bit 24: phy b fixed 100 full duplex
// RQ11 - link detection enforces fixed link on phy b
// RQ12 - enhanced detection resets phy b on errors
// RQ13 - reads accepted in reset and not-ready states; the code gives no answer while rst is high
// RQ14 - byte and partial width reads allowed
// RQ15 - bit 23 does for phy a what 24 does
// RQ16 - phy bit defaults loaded from speed straps
// RQ17 - bits 4:0 led polarity, inverse strap default
// RQ18 - writes to ready and reserved bits ignored
package hcr_pkg;
    localparam logic [11:0] HCR_ADDR_CONFIG = 12'h074;
    localparam logic [11:0] HCR_ADDR_PMT = 12'h084;
    localparam logic [11:0] HCR_ADDR_BYTE_TEST = 12'h064;
    localparam logic [11:0] HCR_ADDR_RST_CONTROL = 12'h1f8;
    localparam int HCR_BIT_READY = 27;
    localparam int HCR_BIT_XOVR_B = 26;
    localparam int HCR_BIT_XOVR_A = 25;
    localparam int HCR_BIT_FIXED_B = 24;
    localparam int HCR_BIT_FIXED_A = 23;
    localparam int HCR_LED_MSB = 4;
    localparam int HCR_NUM_LED = 5;
    localparam int HCR_PMT_READY_BIT = 0;
    localparam logic [31:0] HCR_WR_MASK = 32'h0780_001f;
    localparam logic [31:0] HCR_BYTE_TEST_VAL = 32'h8765_4321;
    // settle time after reset before ready rises
    localparam int HCR_SETTLE_NS = 100;
    localparam int HCR_CLK_NS = 5;
    localparam int HCR_SETTLE_CYC = (HCR_SETTLE_NS + HCR_CLK_NS - 1) / HCR_CLK_NS;
    localparam logic [7:0] HCR_SETTLE_CYC_W = 8'(HCR_SETTLE_CYC);
    typedef enum logic [2:0] {
        HCR_ST_LOAD = 3'b001,
        HCR_ST_SETTLE = 3'b010,
        HCR_ST_READY = 3'b100
    } hcr_state_type;
endpackage : hcr_pkg

// ===== core/hcr_phy_if.sv
// interface: per-phy controls passed from the register to the phy control module
`timescale 1ns/1ps
`default_nettype none
interface hcr_phy_if;
    logic [1:0] xovr_dis;
    logic [1:0] autoneg_off;
    logic [1:0] special_override;
    logic [1:0] special_straight;
    logic [1:0] mi_link_en;
    logic [1:0] enh_link_en;
    logic [1:0] link_err;
    logic [1:0] crossover_en;
    logic [1:0] straight_sel;
    logic [1:0] fixed_100fd;
    logic [1:0] enforce_fixed;
    logic [1:0] phy_reset_req;
    logic [1:0] renegotiate_req;
    modport reg_side (output xovr_dis, autoneg_off, special_override, special_straight,
        mi_link_en, enh_link_en, link_err,
        input crossover_en, straight_sel, fixed_100fd, enforce_fixed,
        phy_reset_req, renegotiate_req);
    modport phy_side (input xovr_dis, autoneg_off, special_override, special_straight,
        mi_link_en, enh_link_en, link_err,
        output crossover_en, straight_sel, fixed_100fd, enforce_fixed,
        phy_reset_req, renegotiate_req);
endinterface : hcr_phy_if
`default_nettype wire

// ===== core/hcr_phy_ctl.sv
// module: per-phy crossover and fixed-speed control derived from register bits
`timescale 1ns/1ps
`default_nettype none
module hcr_phy_ctl (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register side
    hcr_phy_if.phy_side p
);
    import hcr_pkg::*;

    logic [1:0] xo_ff, st_ff, fx_ff, ef_ff, pr_ff, ar_ff;
    logic [1:0] nxt_xo, nxt_st, nxt_fx, nxt_ef, nxt_pr, nxt_ar;

    ////////////////////////////////////////////////////////////////////
    // index 0 is phy a, index 1 is phy b; one loop keeps both identical
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_phy
            always_comb begin
                // special register has the final word on crossover
                if (p.special_override[g]) begin
                    nxt_xo[g] = 1'b0; // RQ9
                    nxt_st[g] = p.special_straight[g]; // RQ9
                end else begin
                    nxt_xo[g] = ~p.xovr_dis[g]; // RQ7 RQ8
                    nxt_st[g] = p.xovr_dis[g]; // RQ7 RQ8
                end
                nxt_fx[g] = p.autoneg_off[g]; // RQ10 RQ15
                nxt_ef[g] = p.autoneg_off[g] & p.mi_link_en[g]; // RQ11 RQ15
                // errors reset the phy instead of renegotiating when fixed
                nxt_pr[g] = p.enh_link_en[g] & p.link_err[g] & p.autoneg_off[g]; // RQ12 RQ15
                nxt_ar[g] = p.enh_link_en[g] & p.link_err[g] & ~p.autoneg_off[g];
            end
        end
    endgenerate

    // registered outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            xo_ff <= 2'h0;
            st_ff <= 2'h0;
            fx_ff <= 2'h0;
            ef_ff <= 2'h0;
            pr_ff <= 2'h0;
            ar_ff <= 2'h0;
        end else begin
            xo_ff <= nxt_xo;
            st_ff <= nxt_st;
            fx_ff <= nxt_fx;
            ef_ff <= nxt_ef;
            pr_ff <= nxt_pr;
            ar_ff <= nxt_ar;
        end
    end

    assign p.crossover_en = xo_ff;
    assign p.straight_sel = st_ff;
    assign p.fixed_100fd = fx_ff;
    assign p.enforce_fixed = ef_ff;
    assign p.phy_reset_req = pr_ff;
    assign p.renegotiate_req = ar_ff;
endmodule : hcr_phy_ctl
`default_nettype wire

// ===== core/hcr_top.sv
// module: hardware configuration register with ready flag and phy controls
`timescale 1ns/1ps
`default_nettype none
module hcr_top (
    // clock and reset (rst covers every reset source)
    input wire logic clock,
    input wire logic rst,
    // host register port
    input wire logic [11:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // internal device status
    input wire logic device_stable,
    // configuration straps
    input wire logic phy_a_fixed_speed_strap,
    input wire logic phy_b_fixed_speed_strap,
    input wire logic [hcr_pkg::HCR_LED_MSB:0] led_polarity_straps,
    // phy special register and link detection inputs, index 0 phy a
    input wire logic [1:0] special_override,
    input wire logic [1:0] special_straight,
    input wire logic [1:0] mi_link_en,
    input wire logic [1:0] enh_link_en,
    input wire logic [1:0] link_err,
    // outputs
    output logic ready,
    output logic pmt_ready,
    output logic ready_int_set,
    output logic [hcr_pkg::HCR_LED_MSB:0] led_polarity,
    output logic [1:0] crossover_en,
    output logic [1:0] straight_sel,
    output logic [1:0] fixed_100fd,
    output logic [1:0] enforce_fixed,
    output logic [1:0] phy_reset_req,
    output logic [1:0] renegotiate_req,
    output logic host_access_err
);
    import hcr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for pin-level inputs
    logic [7:0] s1_ff, s2_ff;
    logic [7:0] pins;
    logic [1:0] ov_s1_ff, ov_s2_ff, stv_s1_ff, stv_s2_ff;
    logic [1:0] mi_s1_ff, mi_s2_ff, en_s1_ff, en_s2_ff, er_s1_ff, er_s2_ff;
    assign pins = {phy_b_fixed_speed_strap, phy_a_fixed_speed_strap, led_polarity_straps,
        device_stable};
    always_ff @(posedge clock) begin
        s1_ff <= pins;
        s2_ff <= s1_ff;
        ov_s1_ff <= special_override;
        ov_s2_ff <= ov_s1_ff;
        stv_s1_ff <= special_straight;
        stv_s2_ff <= stv_s1_ff;
        mi_s1_ff <= mi_link_en;
        mi_s2_ff <= mi_s1_ff;
        en_s1_ff <= enh_link_en;
        en_s2_ff <= en_s1_ff;
        er_s1_ff <= link_err;
        er_s2_ff <= er_s1_ff;
    end

    ////////////////////////////////////////////////////////////////////
    // ready sequencing: straps load after reset release, then settle
    hcr_state_type st_ff, nxt_st;
    logic [7:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy;
    logic irq_ff, nxt_irq;
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_rdy = rdy_ff;
        unique case (st_ff)
            HCR_ST_LOAD: begin
                nxt_st = HCR_ST_SETTLE;
                nxt_cnt = 8'h00;
            end
            HCR_ST_SETTLE: begin
                // counting only while the core reports stable
                if (!s2_ff[0]) begin
                    nxt_cnt = 8'h00;
                end else if (cnt_ff == HCR_SETTLE_CYC_W - 8'h01) begin
                    nxt_st = HCR_ST_READY;
                    nxt_rdy = 1'b1; // RQ1
                end else begin
                    nxt_cnt = cnt_ff + 8'h01;
                end
            end
            HCR_ST_READY: begin
                // losing stability drops ready and restarts settling
                if (!s2_ff[0]) begin
                    nxt_st = HCR_ST_SETTLE;
                    nxt_rdy = 1'b0;
                    nxt_cnt = 8'h00;
                end
            end
            default: begin
                nxt_st = HCR_ST_LOAD;
                nxt_rdy = 1'b0;
            end
        endcase
        nxt_irq = nxt_rdy & ~rdy_ff; // RQ3
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= HCR_ST_LOAD;
            cnt_ff <= 8'h00;
            rdy_ff <= 1'b0; // RQ2
            irq_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
            irq_ff <= nxt_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // writable fields and host access
    logic [31:0] cfg_ff, nxt_cfg;
    logic [31:0] rd_ff, nxt_rd;
    logic rv_ff, nxt_rv;
    logic err_ff, nxt_err;
    logic [31:0] be_mask, rd_word;
    logic hit_cfg, allowed_rd;
    assign be_mask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
    assign hit_cfg = (reg_addr == HCR_ADDR_CONFIG);
    assign allowed_rd = hit_cfg || (reg_addr == HCR_ADDR_PMT) ||
        (reg_addr == HCR_ADDR_BYTE_TEST) || (reg_addr == HCR_ADDR_RST_CONTROL); // RQ4

    always_comb begin
        rd_word = cfg_ff & HCR_WR_MASK;
        rd_word[HCR_BIT_READY] = rdy_ff; // RQ1 RQ6
        nxt_cfg = cfg_ff;
        nxt_rd = rd_ff;
        nxt_rv = 1'b0;
        nxt_err = 1'b0;
        if (st_ff == HCR_ST_LOAD) begin
            // defaults come from synchronised straps, sampled after release
            nxt_cfg = 32'h0000_0000;
            nxt_cfg[HCR_BIT_XOVR_B] = s2_ff[7]; // RQ16
            nxt_cfg[HCR_BIT_FIXED_B] = s2_ff[7]; // RQ16
            nxt_cfg[HCR_BIT_XOVR_A] = s2_ff[6]; // RQ16
            nxt_cfg[HCR_BIT_FIXED_A] = s2_ff[6]; // RQ16
            nxt_cfg[HCR_LED_MSB:0] = ~s2_ff[HCR_LED_MSB+1:1]; // RQ17
        end else if (reg_wr && hit_cfg) begin
            // only writable bits under the active byte lanes change
            nxt_cfg = (cfg_ff & ~(HCR_WR_MASK & be_mask)) |
                (reg_wdata & HCR_WR_MASK & be_mask); // RQ18
        end
        if (reg_rd && hit_cfg) begin
            // answered in every state once rst is low; unselected lanes read zero
            nxt_rd = rd_word & be_mask; // RQ13 RQ14
            nxt_rv = 1'b1; // RQ13
        end else if (reg_rd) begin
            nxt_rd = 32'h0000_0000;
            nxt_rv = 1'b1;
            nxt_err = ~rdy_ff & ~allowed_rd; // RQ4
        end
        if (reg_wr && !rdy_ff) begin
            nxt_err = 1'b1; // RQ5
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_ff <= 32'h0000_0000;
            rd_ff <= 32'h0000_0000;
            rv_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            rd_ff <= nxt_rd;
            rv_ff <= nxt_rv;
            err_ff <= nxt_err;
        end
    end

    // led polarity held in a flop that follows the field
    logic [HCR_LED_MSB:0] led_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            led_ff <= 5'h00;
        end else begin
            led_ff <= cfg_ff[HCR_LED_MSB:0]; // RQ17
        end
    end

    ////////////////////////////////////////////////////////////////////
    // phy control
    hcr_phy_if phy_bus ();
    assign phy_bus.xovr_dis = {cfg_ff[HCR_BIT_XOVR_B], cfg_ff[HCR_BIT_XOVR_A]}; // RQ7 RQ8
    assign phy_bus.autoneg_off = {cfg_ff[HCR_BIT_FIXED_B], cfg_ff[HCR_BIT_FIXED_A]}; // RQ10 RQ15
    assign phy_bus.special_override = ov_s2_ff;
    assign phy_bus.special_straight = stv_s2_ff;
    assign phy_bus.mi_link_en = mi_s2_ff;
    assign phy_bus.enh_link_en = en_s2_ff;
    assign phy_bus.link_err = er_s2_ff;

    hcr_phy_ctl u_phy (
        .clock(clock),
        .rst(rst),
        .p(phy_bus.phy_side)
    );

    // outputs straight from flops
    assign reg_rdata = rd_ff;
    assign reg_rvalid = rv_ff;
    assign ready = rdy_ff;
    assign pmt_ready = rdy_ff; // RQ6
    assign ready_int_set = irq_ff;
    assign led_polarity = led_ff;
    assign crossover_en = phy_bus.crossover_en;
    assign straight_sel = phy_bus.straight_sel;
    assign fixed_100fd = phy_bus.fixed_100fd;
    assign enforce_fixed = phy_bus.enforce_fixed;
    assign phy_reset_req = phy_bus.phy_reset_req;
    assign renegotiate_req = phy_bus.renegotiate_req;
    assign host_access_err = err_ff;
endmodule : hcr_top
`default_nettype wire

// ===== test/hcr_assertions.sv
// checker: port-level properties of the configuration register
`timescale 1ns/1ps
`default_nettype none
module hcr_assertions
    import hcr_pkg::*;
(
    // clock, reset, host port
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    // status and controls
    input wire logic ready,
    input wire logic pmt_ready,
    input wire logic ready_int_set,
    input wire logic [4:0] led_polarity,
    input wire logic [1:0] phy_reset_req,
    input wire logic [1:0] renegotiate_req,
    input wire logic host_access_err
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // answers to reads
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read got no answer");
    a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without read");
    a_reserved_zero: assert property (reg_rvalid && $past(reg_addr) == HCR_ADDR_CONFIG
        |-> reg_rdata[31:28] == 4'h0 && reg_rdata[22:5] == 18'h0)
        else $error("reserved bits not zero");
    a_ready_bit: assert property (reg_rvalid && $past(reg_addr) == HCR_ADDR_CONFIG
        && $past(reg_be[3]) |-> reg_rdata[27] == $past(ready))
        else $error("ready bit read wrong");
    // ready flag and its event
    a_ready_mirror: assert property (pmt_ready == ready)
        else $error("two ready views differ");
    a_int_on_rise: assert property ($rose(ready) |-> ready_int_set)
        else $error("no event on ready rise");
    a_int_cause: assert property (ready_int_set |-> $rose(ready))
        else $error("event without ready rise");
    a_ready_reset: assert property ($fell(rst) |-> !ready && !ready_int_set)
        else $error("ready high after reset");
    a_access_err: assert property (reg_wr && !ready |=> host_access_err)
        else $error("early write not flagged");
    // only the first edge after release loads straps; the check skips writes at the first two
    a_led_write: assert property (reg_wr && reg_addr == HCR_ADDR_CONFIG && reg_be[0]
        && !$past(rst) && !$past(rst, 2) |=> ##1 led_polarity == $past(reg_wdata[4:0], 2))
        else $error("led polarity not written");
    a_req_exclusive: assert property (!(|(phy_reset_req & renegotiate_req)))
        else $error("reset and restart together");
    c_ready: cover property ($rose(ready));
    c_write: cover property (reg_wr && reg_addr == HCR_ADDR_CONFIG);
    c_phy_reset: cover property (|phy_reset_req);
endmodule // hcr_assertions
bind hcr_top hcr_assertions i_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ready(ready), .pmt_ready(pmt_ready),
    .ready_int_set(ready_int_set), .led_polarity(led_polarity),
    .phy_reset_req(phy_reset_req), .renegotiate_req(renegotiate_req),
    .host_access_err(host_access_err));
`default_nettype wire

// ===== test/hcr_host_model.sv
// host model: drives the register port at the falling edge
`timescale 1ns/1ps
`default_nettype none
module hcr_host_model
    import hcr_pkg::*;
(
    // clock
    input wire logic clock,
    // register port
    output logic [11:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [3:0] reg_be,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid
);
    ////////////////////////////////////////////////////////////////////////
    // idle levels before the first request
    initial begin
        reg_addr = 12'h000;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_be = 4'h0;
        reg_wdata = 32'h0;
    end
    // released lines show the inverse so stale values never pass
    task automatic rd(input logic [11:0] a, input logic [3:0] be, output logic [31:0] d,
        output logic v);
        @(negedge clock);
        reg_addr = a;
        reg_be = be;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        v = reg_rvalid;
        d = reg_rdata;
        reg_addr = ~a;
        reg_be = ~be;
    endtask
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_be = be;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule // hcr_host_model
`default_nettype wire

// ===== test/tb_hardware_config_register.sv
// testbench: configuration register scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_hardware_config_register;
    import hcr_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic device_stable = 1'b0;
    logic strap_a = 1'b1;
    logic strap_b = 1'b0;
    logic [4:0] led_straps = 5'h0a;
    logic [1:0] sp_ovr = 2'b00;
    logic [1:0] sp_str = 2'b00;
    logic [1:0] mi_en = 2'b00;
    logic [1:0] enh_en = 2'b00;
    logic [1:0] lerr = 2'b00;
    logic [11:0] reg_addr;
    logic reg_rd, reg_wr, reg_rvalid, ready, pmt_ready, ready_int_set, host_access_err;
    logic [3:0] reg_be;
    logic [31:0] reg_wdata, reg_rdata;
    logic [4:0] led_polarity;
    logic [1:0] crossover_en, straight_sel, fixed_100fd, enforce_fixed;
    logic [1:0] phy_reset_req, renegotiate_req;
    int errors = 0;
    int num_checks = 0;
    int n_err = 0;
    int n_int = 0;
    ////////////////////////////////////////////////////////////////////////
    always #2.5 clock = ~clock;
    // count one-cycle pulses mid-cycle, where they are settled, so none is missed
    always @(negedge clock) begin
        if (host_access_err === 1'b1) n_err++;
        if (ready_int_set === 1'b1) n_int++;
    end
    hcr_host_model i_host (.clock(clock), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    hcr_top i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .device_stable(device_stable), .phy_a_fixed_speed_strap(strap_a),
        .phy_b_fixed_speed_strap(strap_b), .led_polarity_straps(led_straps),
        .special_override(sp_ovr), .special_straight(sp_str), .mi_link_en(mi_en),
        .enh_link_en(enh_en), .link_err(lerr), .ready(ready), .pmt_ready(pmt_ready),
        .ready_int_set(ready_int_set), .led_polarity(led_polarity), .crossover_en(crossover_en),
        .straight_sel(straight_sel), .fixed_100fd(fixed_100fd), .enforce_fixed(enforce_fixed),
        .phy_reset_req(phy_reset_req), .renegotiate_req(renegotiate_req),
        .host_access_err(host_access_err));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // read one place and compare answer and data
    task automatic rdc(input logic [11:0] a, input logic [3:0] be, input logic [31:0] e);
        logic [31:0] d;
        logic v;
        i_host.rd(a, be, d, v);
        chk(32'(v), 32'h1, "read answer");
        chk(d, e, "read data");
    endtask
    task automatic t_defaults();
        rdc(HCR_ADDR_CONFIG, 4'hf, 32'h0280_0015);
        chk(32'(led_polarity), 32'h15, "led default");
        chk(32'(crossover_en), 32'h2, "crossover default");
        chk(32'(straight_sel), 32'h1, "straight default");
        chk(32'(fixed_100fd), 32'h1, "fixed default");
    endtask
    task automatic t_not_ready();
        logic [31:0] d;
        logic v;
        logic [11:0] ok_addr [4] = '{HCR_ADDR_CONFIG, HCR_ADDR_PMT, HCR_ADDR_BYTE_TEST,
            HCR_ADDR_RST_CONTROL};
        for (int i = 0; i < 4; i++) begin
            i_host.rd(ok_addr[i], 4'hf, d, v);
            chk(32'(v), 32'h1, "allowed read answer");
        end
        repeat (2) @(negedge clock);
        chk(32'(n_err), 32'h0, "allowed reads flagged");
        i_host.rd(12'h100, 4'hf, d, v);
        i_host.wr(HCR_ADDR_CONFIG, 4'h0, 32'h0);
        repeat (2) @(negedge clock);
        chk(32'(n_err), 32'h2, "early accesses not flagged");
    endtask
    task automatic t_ready();
        int cnt;
        device_stable = 1'b1;
        cnt = 0;
        while (ready !== 1'b1 && cnt < 60) begin
            @(negedge clock);
            cnt++;
        end
        if (cnt >= 60) begin
            errors++;
            close_out();
        end
        chk(32'(cnt >= 21 && cnt <= 23), 32'h1, "settle time");
        chk(32'(pmt_ready), 32'h1, "ready mirror");
        rdc(HCR_ADDR_CONFIG, 4'h8, 32'h0a00_0000);
        chk(32'(n_int), 32'h1, "ready event count");
    endtask
    task automatic t_write();
        i_host.wr(HCR_ADDR_CONFIG, 4'hf, 32'hffff_ffff);
        rdc(HCR_ADDR_CONFIG, 4'hf, 32'h0f80_001f);
        chk(32'(crossover_en), 32'h0, "crossover off");
        chk(32'(straight_sel), 32'h3, "straight both");
        chk(32'(fixed_100fd), 32'h3, "fixed both");
        chk(32'(led_polarity), 32'h1f, "led written");
        i_host.wr(HCR_ADDR_CONFIG, 4'h1, 32'h0);
        rdc(HCR_ADDR_CONFIG, 4'h1, 32'h0);
        rdc(HCR_ADDR_CONFIG, 4'hf, 32'h0f80_0000);
        i_host.wr(HCR_ADDR_CONFIG, 4'hf, 32'h0);
        rdc(HCR_ADDR_CONFIG, 4'hf, 32'h0800_0000);
        chk(32'(crossover_en), 32'h3, "crossover on");
        chk(32'(fixed_100fd), 32'h0, "fixed off");
    endtask
    task automatic t_phy();
        sp_ovr = 2'b10;
        sp_str = 2'b10;
        mi_en = 2'b11;
        i_host.wr(HCR_ADDR_CONFIG, 4'hf, 32'h0080_0000);
        repeat (5) @(negedge clock);
        chk(32'(crossover_en), 32'h1, "override crossover");
        chk(32'(straight_sel), 32'h2, "override straight");
        chk(32'(enforce_fixed), 32'h1, "enforce fixed");
        enh_en = 2'b11;
        lerr = 2'b11;
        repeat (5) @(negedge clock);
        chk(32'(phy_reset_req), 32'h1, "phy reset on error");
        chk(32'(renegotiate_req), 32'h2, "restart on error");
    endtask
    task automatic t_rereset();
        logic [31:0] d;
        logic v;
        strap_b = 1'b1;
        led_straps = 5'h1f;
        repeat (3) @(negedge clock);
        rst = 1'b1;
        i_host.rd(HCR_ADDR_CONFIG, 4'hf, d, v);
        chk(32'(v), 32'h0, "answer in reset");
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        chk(32'(ready), 32'h0, "ready after reset");
        rdc(HCR_ADDR_CONFIG, 4'hf, 32'h0780_0000);
    endtask
    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        t_defaults();
        t_not_ready();
        t_ready();
        t_write();
        t_phy();
        t_rereset();
        close_out();
    end
endmodule // tb_hardware_config_register
`default_nettype wire
